// ### verilog/lcr_defs.svh
// offsets, field positions and reset values of the logical capability registers
// assumes byte offsets within the endpoint configuration space
`ifndef LCR_DEFS_SVH
`define LCR_DEFS_SVH

// ==========================================
// capability register offsets
`define LCR_OFS_SWITCH_PORT_INFO 8'h14
`define LCR_OFS_SOURCE_OPS 8'h18
`define LCR_OFS_DEST_OPS 8'h1c

// ==========================================
// command and status space
`define LCR_CSR_FIRST 8'h40
`define LCR_CSR_LAST 8'hfc
`define LCR_OFS_LOGICAL_CTRL 8'h4c
`define LCR_OFS_BASE_HIGH 8'h58
`define LCR_OFS_BASE_LOW 8'h5c
`define LCR_OFS_BASE_NODE_ID 8'h60
`define LCR_OFS_HOST_LOCK 8'h68
`define LCR_OFS_COMPONENT_TAG 8'h6c

// ==========================================
// field positions and fixed values
`define LCR_OPS_HI 15
`define LCR_OPS_LO 3
`define LCR_OPS_W 13
`define LCR_PORT_WRITE_CAP 1'b0
`define LCR_SWITCH_CAP 1'b0
`define LCR_LOGICAL_CTRL_VAL 32'h0000_0001
`define LCR_BASE_HIGH_VAL 32'h0000_0000
`define LCR_BASE_HI 30
`define LCR_BASE_LO 21
`define LCR_BASE_W 10
`define LCR_NODE_ID_W 24
`define LCR_LOCK_FREE 16'hffff
`define LCR_TAG_RST 32'h0000_0000

`endif

// ### verilog/lcr_pkg.sv
// types shared by the logical capability register files
// assumes lcr_defs.svh is on the include path
`include "lcr_defs.svh"

package lcr_pkg;
  typedef logic [31:0] lcr_word_t;
  typedef logic [`LCR_OPS_W-1:0] lcr_ops_t;
endpackage

// ### verilog/lcr_ops_word.sv
// builds one operations capability word from its generation-time settings
// assumes the settings are constants fixed at elaboration
`timescale 1ns/10ps
`default_nettype none
`include "lcr_defs.svh"

module lcr_ops_word
#(
  parameter lcr_pkg::lcr_ops_t OPS = '0
)
(
  // capability word
  output wire logic [31:0] word_o
);

  // ==========================================
  // word layout
  // reserved and implementation-defined fields tied low
  assign word_o = {14'h0000, 2'h0, OPS, `LCR_PORT_WRITE_CAP, 2'h0};

endmodule
`default_nettype wire

// ### verilog/lcr_top.sv
// logical-layer capability and command-and-status register port
// assumes the configuration fabric routes every csr access here, one per cycle
//
// What this block does
// - switch port information reads zero since switching is never supported.
// - switch capability flag is constant zero.
// - source operations word returns generation-time settings in bits 15 to 3.
// - operation capability bits never alter how transactions are issued.
// - reserved and implementation-defined source bits read zero.
// - port-write capability bit reads zero in both operations words.
// - destination operations word mirrors the source layout with own settings.
// - command-and-status registers live here beside the capability registers.
// - reserved csr offsets 0x40-0x48, 0x50-0x54, 0x64, 0x70-0xfc decoded.
// - control, base high/low, node id, host lock, tag at their offsets.
`timescale 1ns/10ps
`default_nettype none
`include "lcr_defs.svh"

module lcr_top
#(
  parameter lcr_pkg::lcr_ops_t SOURCE_OPS = 13'h1fff,
  parameter lcr_pkg::lcr_ops_t DEST_OPS = 13'h1fff,
  parameter logic [`LCR_BASE_W-1:0] BASE_LOW_RST = 10'h000,
  parameter logic [`LCR_NODE_ID_W-1:0] NODE_ID_RST = 24'h00_0000
)
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  // configuration register port
  input wire logic CFG_REQ_I,
  input wire logic CFG_WRITE_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [3:0] CFG_BE_I,
  input wire logic [31:0] CFG_WDATA_I,
  output logic CFG_ACK_O,
  output logic [31:0] CFG_RDATA_O,
  // register values used elsewhere in the endpoint
  output logic SWITCH_CAP_O,
  output logic [`LCR_BASE_W-1:0] BASE_LOW_O,
  output logic [`LCR_NODE_ID_W-1:0] NODE_ID_O,
  output logic [15:0] HOST_ID_O,
  output logic [31:0] COMPONENT_TAG_O
);

  // ==========================================
  // capability words
  lcr_pkg::lcr_word_t src_word;
  lcr_pkg::lcr_word_t dst_word;
  lcr_pkg::lcr_word_t rd_d;
  logic [7:0] word_addr;
  logic wr_en;
  logic [31:0] wmask;
  logic rd_en;
  // write selects, one per writable word
  logic sel_base_low;
  logic sel_node_id;
  logic sel_host_lock;
  logic sel_tag;
  logic [`LCR_BASE_W-1:0] base_low_q;
  logic [`LCR_NODE_ID_W-1:0] node_id_q;
  logic [15:0] host_id_q;
  logic [31:0] tag_q;

  lcr_ops_word #(.OPS(SOURCE_OPS)) u_src_ops
  (
    .word_o(src_word)
  );

  lcr_ops_word #(.OPS(DEST_OPS)) u_dst_ops
  (
    .word_o(dst_word)
  );

  // ==========================================
  // decode
  // low address bits dropped: every register is one aligned word
  assign word_addr = {CFG_ADDR_I[7:2], 2'b00};
  assign wr_en = CFG_REQ_I & CFG_WRITE_I;
  assign wmask = {{8{CFG_BE_I[3]}}, {8{CFG_BE_I[2]}}, {8{CFG_BE_I[1]}}, {8{CFG_BE_I[0]}}};
  assign rd_en = CFG_REQ_I & ~CFG_WRITE_I;

  // ==========================================
  // write selects
  // reserved and read-only words get no select, so writes there fall away
  assign sel_base_low = wr_en && (word_addr == `LCR_OFS_BASE_LOW);
  assign sel_node_id = wr_en && (word_addr == `LCR_OFS_BASE_NODE_ID);
  // lock compares a whole field, so a half-written id must not count
  assign sel_host_lock = wr_en && (word_addr == `LCR_OFS_HOST_LOCK) &&
                         (CFG_BE_I[1:0] == 2'b11);
  assign sel_tag = wr_en && (word_addr == `LCR_OFS_COMPONENT_TAG);

  always_comb
  begin
    case (word_addr)
      // operation capability bits only feed the read path, never any issue logic
      `LCR_OFS_SWITCH_PORT_INFO: rd_d = 32'h0000_0000;
      `LCR_OFS_SOURCE_OPS: rd_d = src_word;
      `LCR_OFS_DEST_OPS: rd_d = dst_word;
      `LCR_OFS_LOGICAL_CTRL: rd_d = `LCR_LOGICAL_CTRL_VAL;
      `LCR_OFS_BASE_HIGH: rd_d = `LCR_BASE_HIGH_VAL;
      `LCR_OFS_BASE_LOW: rd_d = {1'b0, base_low_q, 21'h00_0000};
      `LCR_OFS_BASE_NODE_ID: rd_d = {8'h00, node_id_q};
      `LCR_OFS_HOST_LOCK: rd_d = {16'h0000, host_id_q};
      `LCR_OFS_COMPONENT_TAG: rd_d = tag_q;
      // reserved csr holes and unowned offsets read zero
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // answer: every access acknowledged, no error path
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      CFG_ACK_O <= 1'b0;
    else
      CFG_ACK_O <= CFG_REQ_I;
  end

  // data idles low so a write or a gap never shows a stale word
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      CFG_RDATA_O <= 32'h0000_0000;
    else if (rd_en)
      CFG_RDATA_O <= rd_d;
    else
      CFG_RDATA_O <= 32'h0000_0000;
  end

  // ==========================================
  // writable csr fields
  // bits 20:0 of the base word are never stored, they always read zero
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      base_low_q <= BASE_LOW_RST;
    else if (sel_base_low)
      base_low_q <= (base_low_q & ~wmask[`LCR_BASE_HI:`LCR_BASE_LO]) |
                    (CFG_WDATA_I[`LCR_BASE_HI:`LCR_BASE_LO] &
                     wmask[`LCR_BASE_HI:`LCR_BASE_LO]);
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      node_id_q <= NODE_ID_RST;
    else if (sel_node_id)
      node_id_q <= (node_id_q & ~wmask[23:0]) | (CFG_WDATA_I[23:0] & wmask[23:0]);
  end

  // lock taken by a write while free, freed when the holder writes its id again; both low bytes must be enabled for any effect
  // writing the free pattern while free leaves it free, so no lock is taken
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      host_id_q <= `LCR_LOCK_FREE;
    else if (sel_host_lock)
    begin
      if (host_id_q == `LCR_LOCK_FREE)
        host_id_q <= CFG_WDATA_I[15:0];
      else if (CFG_WDATA_I[15:0] == host_id_q)
        host_id_q <= `LCR_LOCK_FREE;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      tag_q <= `LCR_TAG_RST;
    else if (sel_tag)
      tag_q <= (tag_q & ~wmask) | (CFG_WDATA_I & wmask);
  end

  // ==========================================
  // exported copies, one flop stage so outputs come from flops
  // copies lag the registers by a cycle; a register read is the exact view
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      SWITCH_CAP_O <= 1'b0;
    else
      SWITCH_CAP_O <= `LCR_SWITCH_CAP;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      BASE_LOW_O <= '0;
    else
      BASE_LOW_O <= base_low_q;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      NODE_ID_O <= '0;
    else
      NODE_ID_O <= node_id_q;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      HOST_ID_O <= `LCR_LOCK_FREE;
    else
      HOST_ID_O <= host_id_q;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      COMPONENT_TAG_O <= `LCR_TAG_RST;
    else
      COMPONENT_TAG_O <= tag_q;
  end

endmodule
`default_nettype wire

// ### test/lcr_monitor.sv
// assertions on the register port of lcr_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module lcr_monitor (
  input wire logic MCLK_I, RST_B_I, CFG_REQ_I, CFG_WRITE_I, CFG_ACK_O, SWITCH_CAP_O,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [31:0] CFG_RDATA_O
);
  wire rd = CFG_REQ_I && !CFG_WRITE_I;
  wire [5:0] w = CFG_ADDR_I[7:2];
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  a_ack_next: assert property (CFG_REQ_I |=> CFG_ACK_O) else $error("no ack");
  a_ack_cause: assert property (CFG_ACK_O |-> $past(CFG_REQ_I)) else $error("stray ack");
  a_rdata_idle: assert property (!CFG_ACK_O |-> CFG_RDATA_O == 0) else $error("idle data");
  a_write_quiet: assert property (CFG_REQ_I && CFG_WRITE_I |=> CFG_RDATA_O == 0)
    else $error("write data");
  a_switch_zero: assert property (SWITCH_CAP_O == 1'b0) else $error("switch flag");
  a_ops_fixed: assert property (rd && w[5:1] == 5'h03 |=> CFG_RDATA_O[31:16] == 0
    && CFG_RDATA_O[2:0] == 0) else $error("ops bits");
  a_ctrl_word: assert property (rd && w == 6'h13 |=> CFG_RDATA_O == 32'h1) else $error("ctrl");
  a_reserved_zero: assert property (rd && (w inside {6'h05, [6'h10:6'h12], 6'h14, 6'h15,
    6'h16, 6'h19, [6'h1c:6'h3f]}) |=> CFG_RDATA_O == 0) else $error("reserved");
endmodule
bind lcr_top lcr_monitor mon (.MCLK_I, .RST_B_I, .CFG_REQ_I, .CFG_WRITE_I, .CFG_ACK_O,
  .SWITCH_CAP_O, .CFG_ADDR_I, .CFG_RDATA_O);
`default_nettype wire

// ### test/lcr_fabric.sv
// configuration fabric model feeding the register port
// assumes offsets below 0x100 belong to this port
`timescale 1ns/10ps
`default_nettype none
module lcr_fabric (
  input wire logic go_i, wr_i,
  input wire logic [15:0] ofs_i,
  input wire logic [31:0] wd_i,
  output logic req_o, write_o,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o
);
  // idle lines toggle so a stale value never looks valid
  assign req_o = go_i && ofs_i[15:8] == 8'h00;
  assign write_o = wr_i;
  assign addr_o = go_i ? ofs_i[7:0] : ~ofs_i[7:0];
  assign wdata_o = go_i ? wd_i : ~wd_i;
endmodule
`default_nettype wire

// ### test/tb_logical_capability_regs.sv
// self-checking bench of the capability register port
// assumes the fabric model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_logical_capability_regs;
  localparam logic [12:0] S = 13'h1a5c;
  localparam logic [12:0] D = 13'h0b37;
  localparam logic [9:0] BL = 10'h2a5;
  localparam logic [23:0] NI = 24'h3c_5a96;
  logic clk = 0, rst_b = 0, go = 0, wr = 0, ea = 0, ack, req, cw, sw;
  logic [3:0] be = 0;
  logic [7:0] ad;
  logic [9:0] bl;
  logic [23:0] id;
  logic [15:0] hi, ofs = 0;
  logic [31:0] wd = 0, ex = 0, r, cwd, rd, tg, m[4], p[4];
  int seed = 32'hb1e1, fail_count = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  lcr_fabric fab (.go_i(go), .wr_i(wr), .ofs_i(ofs), .wd_i(wd), .req_o(req), .write_o(cw),
    .addr_o(ad), .wdata_o(cwd));
  lcr_top #(.SOURCE_OPS(S), .DEST_OPS(D), .BASE_LOW_RST(BL), .NODE_ID_RST(NI)) uut
    (.MCLK_I(clk), .RST_B_I(rst_b), .CFG_REQ_I(req),
    .CFG_WRITE_I(cw), .CFG_ADDR_I(ad), .CFG_BE_I(be), .CFG_WDATA_I(cwd), .CFG_ACK_O(ack),
    .CFG_RDATA_O(rd), .SWITCH_CAP_O(sw), .BASE_LOW_O(bl), .NODE_ID_O(id), .HOST_ID_O(hi),
    .COMPONENT_TAG_O(tg));
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic init_model;
    m = '{32'h0, {1'b0, BL, 21'h0}, {8'h0, NI}, 32'hffff};
    p = m;
  endtask
  function automatic logic [31:0] mg(input logic [31:0] o, n);
    for (int i = 0; i < 4; i++)
      if (be[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction
  function automatic logic [31:0] rdexp(input logic [5:0] a);
    case (a)
      6'h06: return {16'h0, S, 3'b000};
      6'h07: return {16'h0, D, 3'b000};
      6'h13: return 32'h1;
      6'h17: return m[1];
      6'h18: return m[2];
      6'h1a: return m[3];
      6'h1b: return m[0];
      default: return 32'h0;
    endcase
  endfunction
  // hang guard, well above the 423 cycles the run needs
  always @(posedge clk)
    if (++cyc > 1000)
    begin
      fail_count++;
      end_sim();
    end
  initial
  begin
    init_model();
    repeat (20) @(negedge clk);
    rst_b = 1;
    for (int k = 0; k < 400; k++)
    begin
      @(negedge clk);
      chk(ack, ea);
      chk(rd, ex);
      chk(tg, p[0]);
      chk(bl, p[1][30:21]);
      chk(id, p[2][23:0]);
      chk({sw, hi}, {1'b0, p[3][15:0]});
      p = m;
      // mid-run reset: every register must fall back to its reset value
      if (k == 200)
      begin
        go = 0;
        rst_b = 0;
        repeat (3) @(negedge clk);
        rst_b = 1;
        init_model();
      end
      r = $random(seed);
      {go, wr, be} = {r[1:0] != 0, r[2], r[6:3]};
      ofs = {r[9:7] == 0 ? r[15:8] : 8'h0, r[21:16], 2'b00};
      wd = $random(seed);
      if (r[22]) wd[15:0] = m[3][15:0];
      ea = go && ofs[15:8] == 0;
      ex = ea && !wr ? rdexp(ofs[7:2]) : 32'h0;
      if (ea && wr)
        case (ofs[7:2])
          6'h17: m[1] = mg(m[1], wd) & 32'h7fe00000;
          6'h18: m[2] = mg(m[2], wd) & 32'h00ffffff;
          6'h1b: m[0] = mg(m[0], wd);
          6'h1a: if (be[1:0] == 2'h3) m[3] = m[3] == 32'hffff ? {16'h0, wd[15:0]} :
            (wd[15:0] == m[3][15:0] ? 32'hffff : m[3]);
          default: ;
        endcase
    end
    end_sim();
  end
endmodule
`default_nettype wire
